/* ssr_pkg.sv */
// Shared constants and types for the spindle range switch sequencer.
// Assumes a single 100 MHz clock shared by both ends.
package ssr_pkg;
  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_MHZ          = 100;
  localparam int TIMEOUT_MS       = 1000;
  localparam int TIMEOUT_CYC      = TIMEOUT_MS * 1000 * CLK_MHZ;
  localparam int AUX_LAG_MS       = 50;
  localparam int AUX_LAG_CYC      = AUX_LAG_MS * 1000 * CLK_MHZ;
  localparam int CNT_W            = 27;
  // ----------------------------------------
  // Range encoding and reset values
  // ----------------------------------------
  localparam logic RANGE_HIGH     = 1'b0;
  localparam logic RANGE_LOW      = 1'b1;
  localparam logic RST_RANGE      = 1'b0;
  localparam int SPD_W            = 16;
  localparam logic [SPD_W-1:0] RST_DET_LEVEL = 16'h0000;
  localparam logic [SPD_W-1:0] RST_HYST      = 16'h0014;
  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STAT   = 8'h04;
  localparam logic [7:0] OFS_IRQ    = 8'h08;
  localparam logic [7:0] OFS_MASK   = 8'h0c;
  // Control bit positions
  localparam int CB_REQ   = 0;
  localparam int CB_DUAL  = 1;
  localparam int CB_MRDY  = 2;
  localparam int CB_ESTOP = 3;
  localparam int CB_RIGID = 4;
  // Interrupt bit positions
  localparam int IB_DONE  = 0;
  localparam int IB_ALARM = 1;
  localparam int IB_SEL   = 2;
  localparam int IRQ_W    = 3;
  // Device state machine
  typedef enum logic [2:0] {
    SSR_IDLE, SSR_OPEN, SSR_CLOSE, SSR_DONE, SSR_ALARM
  } ssr_state_t;
  // Host state machine
  typedef enum logic [2:0] {
    SSH_IDLE, SSH_OPEN, SSH_CLOSE, SSH_LAG, SSH_REPORT
  } ssr_host_state_t;
endpackage

/* ssr_if.sv */
// Link between the drive-side sequencer and the machine sequence controller.
// Both ends share CLOCK and ARST_N; the bench joins them.
`timescale 1ns/100ps
interface ssr_if;
  logic range_request;
  logic power_line_select;
  logic range_switch_done;
  logic low_contactor_status;
  logic high_contactor_status;
  logic gear_select_1;
  logic gear_select_2;
  logic below_speed_flag;
  logic machine_ready_in;
  logic emergency_stop_n;
  logic contactor_timeout_alarm;
  logic motor_power_on;

  modport dev
  (
    input  range_request, low_contactor_status, high_contactor_status,
           gear_select_1, gear_select_2, machine_ready_in, emergency_stop_n,
    output power_line_select, range_switch_done, below_speed_flag,
           contactor_timeout_alarm, motor_power_on
  );
  modport msc
  (
    output range_request, low_contactor_status, high_contactor_status,
           gear_select_1, gear_select_2, machine_ready_in, emergency_stop_n,
    input  power_line_select, range_switch_done, below_speed_flag,
           contactor_timeout_alarm, motor_power_on
  );
endinterface

/* ssr_sync.sv */
// Three-stage input synchroniser; output changes once stages two and three agree.
// Assumes the input is asynchronous to CLOCK.
`timescale 1ns/100ps
module ssr_sync
#(
  parameter int W = 1
)
(
  input  wire logic         CLOCK,
  input  wire logic         ARST_N,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  // Shift chain
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s1_ff <= '0;
      s2_ff <= '0;
      s3_ff <= '0;
    end
    else
    begin
      s1_ff <= d;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Accept agreed bits only
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      always_ff @(posedge CLOCK or negedge ARST_N)
      begin
        if (!ARST_N)
          q[i] <= 1'b0;
        else if (s2_ff[i] == s3_ff[i])
          q[i] <= s3_ff[i];
      end
    end
  endgenerate
endmodule

/* ssr_dev.sv */
// Drive-side range switch sequencer: power-line select, contactor check,
// motor power hold-off, timeout alarm and below-speed detection.
// Assumes link inputs arrive asynchronously from the sequence controller.
`timescale 1ns/100ps
// Summary of operation
// - Dual check waits both contactor statuses
// - Single check uses low status only
// - High-to-low: select, open high, close low
// - One means low range, zero high
// - Option blocks high-to-low above speed
// - Alarm if contactors late one second
// - Controller lags status 50 ms
// - Controller drives gear selects to range
// - Switching only when enable bit set
// - Below-speed uses level plus hysteresis
// - Ready and no e-stop before operation
// - Rigid tapping: no switch, ignore flag
// - Power off until done equals request
// - Break before make on windings
// - Flag high below switching point
module ssr_dev
#(
  parameter int TIMEOUT_CYCLES = ssr_pkg::TIMEOUT_CYC
)
(
  input  wire logic                     CLOCK,
  input  wire logic                     ARST_N,
  ssr_if.dev                            LINK,
  input  wire logic                     SWITCH_ENABLE,
  input  wire logic                     DUAL_CHECK,
  input  wire logic                     SPEED_GUARD,
  input  wire logic [ssr_pkg::SPD_W-1:0] MOTOR_SPEED,
  input  wire logic [ssr_pkg::SPD_W-1:0] DETECT_LEVEL,
  input  wire logic [ssr_pkg::SPD_W-1:0] HYSTERESIS,
  output logic                          OPERABLE
);
  import ssr_pkg::*;

  // ----------------------------------------
  // Input synchronisation
  // ----------------------------------------
  logic [5:0] raw_in;
  logic [5:0] syn_in;
  logic       req_s, low_s, high_s, rdy_s, estop_n_s, gear_s;

  assign raw_in = {LINK.range_request, LINK.low_contactor_status,
                   LINK.high_contactor_status, LINK.machine_ready_in,
                   LINK.emergency_stop_n, LINK.gear_select_1 & LINK.gear_select_2};

  ssr_sync #(.W(6)) u_sync
  (
    .CLOCK  (CLOCK),
    .ARST_N (ARST_N),
    .d      (raw_in),
    .q      (syn_in)
  );

  assign {req_s, low_s, high_s, rdy_s, estop_n_s, gear_s} = syn_in;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  ssr_state_t       state_ff, nxt_state;
  logic             sel_ff, nxt_sel;
  logic             done_ff, nxt_done;
  logic             alarm_ff, nxt_alarm;
  logic             below_ff;
  logic             power_ff;
  logic [CNT_W-1:0] tmr_ff;
  logic             opened_ok;
  logic             closed_ok;
  logic             guard_block;

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  // Contactor check, mode chosen by dual-check bit
  always_comb
  begin
    if (DUAL_CHECK)
    begin
      opened_ok = (sel_ff == RANGE_LOW) ? !high_s : !low_s;
      closed_ok = (sel_ff == RANGE_LOW) ? (low_s && !high_s)
                                        : (high_s && !low_s);
    end
    else
    begin
      opened_ok = 1'b1;
      closed_ok = (low_s == sel_ff);
    end
  end

  // High-to-low refused while motor above switchable speed
  assign guard_block = SPEED_GUARD && (req_s == RANGE_LOW)
                       && (done_ff == RANGE_HIGH) && !below_ff;

  // Sequencer next state
  always_comb
  begin
    nxt_state = state_ff;
    nxt_sel   = sel_ff;
    nxt_done  = done_ff;
    nxt_alarm = alarm_ff;
    unique case (state_ff)
      SSR_IDLE:
      begin
        if (SWITCH_ENABLE && (req_s != done_ff) && !guard_block)
        begin
          nxt_sel   = req_s;
          nxt_state = SSR_OPEN;
        end
      end
      SSR_OPEN:
      begin
        if (tmr_ff >= CNT_W'(TIMEOUT_CYCLES - 1))
          nxt_state = SSR_ALARM;
        else if (opened_ok)
          nxt_state = SSR_CLOSE;
      end
      SSR_CLOSE:
      begin
        if (tmr_ff >= CNT_W'(TIMEOUT_CYCLES - 1))
          nxt_state = SSR_ALARM;
        else if (closed_ok)
          nxt_state = SSR_DONE;
      end
      SSR_DONE:
      begin
        nxt_done  = sel_ff;
        nxt_state = SSR_IDLE;
      end
      SSR_ALARM:
      begin
        nxt_alarm = 1'b1;
        if (!estop_n_s)
        begin
          nxt_alarm = 1'b0;
          nxt_sel   = done_ff;
          nxt_state = SSR_IDLE;
        end
      end
    endcase
  end

  // State and outputs of the sequence
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_ff <= SSR_IDLE;
      sel_ff   <= RST_RANGE;
      done_ff  <= RST_RANGE;
      alarm_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      sel_ff   <= nxt_sel;
      done_ff  <= nxt_done;
      alarm_ff <= nxt_alarm;
    end
  end

  // Contactor timer, runs from select change
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      tmr_ff <= '0;
    else if (state_ff == SSR_OPEN || state_ff == SSR_CLOSE)
      tmr_ff <= tmr_ff + 1'b1;
    else
      tmr_ff <= '0;
  end

  // Below-speed flag with hysteresis
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      below_ff <= 1'b1;
    else if (MOTOR_SPEED < DETECT_LEVEL)
      below_ff <= 1'b1;
    else if ({1'b0, MOTOR_SPEED} >= ({1'b0, DETECT_LEVEL} + {1'b0, HYSTERESIS}))
      below_ff <= 1'b0;
  end

  // Motor power held off while switching or not operable
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      power_ff <= 1'b0;
    else
      power_ff <= rdy_s && estop_n_s && (state_ff == SSR_IDLE) && !alarm_ff
                  && (done_ff == req_s) && (gear_s == done_ff);
  end

  // ----------------------------------------
  // Link outputs
  // ----------------------------------------
  // All straight from registers
  assign LINK.power_line_select       = sel_ff;
  assign LINK.range_switch_done       = done_ff;
  assign LINK.contactor_timeout_alarm = alarm_ff;
  assign LINK.below_speed_flag        = below_ff;
  assign LINK.motor_power_on          = power_ff;
  assign OPERABLE                     = power_ff;
endmodule

/* ssr_msc.sv */
// Machine sequence controller end: takes range orders over AHB-Lite and
// drives the winding contactors, gear selects and status lines.
// Assumes a single-slave AHB-Lite bus on CLOCK; link inputs asynchronous.
`timescale 1ns/100ps
module ssr_msc
#(
  parameter int LAG_CYCLES = ssr_pkg::AUX_LAG_CYC
)
(
  input  wire logic        CLOCK,
  input  wire logic        ARST_N,
  ssr_if.msc               LINK,
  input  wire logic        HSEL,
  input  wire logic [31:0] HADDR,
  input  wire logic [1:0]  HTRANS,
  input  wire logic        HWRITE,
  input  wire logic [2:0]  HSIZE,
  input  wire logic [31:0] HWDATA,
  input  wire logic        HREADY,
  output logic      [31:0] HRDATA,
  output logic             HREADYOUT,
  output logic             HRESP,
  output logic             IRQ,
  output logic             LOW_CONTACTOR,
  output logic             HIGH_CONTACTOR
);
  import ssr_pkg::*;

  // ----------------------------------------
  // Link input synchronisation
  // ----------------------------------------
  logic [3:0] syn_in;
  logic       sel_s, done_s, alarm_s, below_s;

  ssr_sync #(.W(4)) u_sync
  (
    .CLOCK  (CLOCK),
    .ARST_N (ARST_N),
    .d      ({LINK.power_line_select, LINK.range_switch_done,
              LINK.contactor_timeout_alarm, LINK.below_speed_flag}),
    .q      (syn_in)
  );
  assign {sel_s, done_s, alarm_s, below_s} = syn_in;

  // ----------------------------------------
  // Bus slave
  // ----------------------------------------
  logic [4:0]       ctrl_ff;
  logic [IRQ_W-1:0] irq_ff, mask_ff;
  logic             wr_pend_ff;
  logic [7:0]       wr_addr_ff;
  logic [31:0]      rdata_ff;
  logic [IRQ_W-1:0] ev;
  logic             addr_ok;

  assign addr_ok = HSEL && HREADY && HTRANS[1];

  // Address phase capture and read data
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      rdata_ff   <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_ff <= addr_ok && HWRITE;
      wr_addr_ff <= HADDR[7:0];
      if (addr_ok && !HWRITE)
      begin
        unique case (HADDR[7:0])
          OFS_CTRL: rdata_ff <= {27'h0, ctrl_ff};
          OFS_STAT: rdata_ff <= {28'h0, below_s, alarm_s, done_s, sel_s};
          OFS_IRQ:  rdata_ff <= {29'h0, irq_ff};
          OFS_MASK: rdata_ff <= {29'h0, mask_ff};
          default:  rdata_ff <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign HRDATA    = rdata_ff;
  assign HREADYOUT = 1'b1;
  assign HRESP     = 1'b0;

  // Control and mask registers
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      ctrl_ff <= 5'h00;
      mask_ff <= 3'h0;
    end
    else if (wr_pend_ff)
    begin
      if (wr_addr_ff == OFS_CTRL)
        ctrl_ff <= HWDATA[4:0];
      if (wr_addr_ff == OFS_MASK)
        mask_ff <= HWDATA[IRQ_W-1:0];
    end
  end

  // ----------------------------------------
  // Contactor sequence
  // ----------------------------------------
  ssr_host_state_t  state_ff;
  logic             low_ff, high_ff;
  logic             low_st_ff, high_st_ff;
  logic             target_ff;
  logic [CNT_W-1:0] lag_ff;
  logic             sel_d_ff, done_d_ff, alarm_d_ff;
  logic             req_ff;

  // Break before make, then report status
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      state_ff   <= SSH_IDLE;
      low_ff     <= 1'b0;
      high_ff    <= 1'b1;
      low_st_ff  <= 1'b0;
      high_st_ff <= 1'b1;
      target_ff  <= RST_RANGE;
      lag_ff     <= '0;
    end
    else
    begin
      unique case (state_ff)
        SSH_IDLE:
          if (sel_s != target_ff)
          begin
            target_ff <= sel_s;
            state_ff  <= SSH_OPEN;
          end
        SSH_OPEN:
        begin
          low_ff     <= 1'b0;
          high_ff    <= 1'b0;
          high_st_ff <= 1'b0;
          if (ctrl_ff[CB_DUAL])
            low_st_ff <= 1'b0;
          lag_ff     <= '0;
          state_ff   <= SSH_LAG;
        end
        SSH_LAG:
        begin
          lag_ff <= lag_ff + 1'b1;
          if (lag_ff >= CNT_W'(LAG_CYCLES - 1))
          begin
            low_ff   <= (target_ff == RANGE_LOW);
            high_ff  <= (target_ff == RANGE_HIGH);
            lag_ff   <= '0;
            state_ff <= SSH_CLOSE;
          end
        end
        SSH_CLOSE:
        begin
          lag_ff <= lag_ff + 1'b1;
          if (lag_ff >= CNT_W'(LAG_CYCLES - 1))
            state_ff <= SSH_REPORT;
        end
        SSH_REPORT:
        begin
          low_st_ff  <= low_ff;
          high_st_ff <= high_ff;
          state_ff   <= SSH_IDLE;
        end
      endcase
    end
  end

  // Event edges for interrupts
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      sel_d_ff   <= 1'b0;
      done_d_ff  <= 1'b0;
      alarm_d_ff <= 1'b0;
    end
    else
    begin
      sel_d_ff   <= sel_s;
      done_d_ff  <= done_s;
      alarm_d_ff <= alarm_s;
    end
  end

  assign ev[IB_DONE]  = done_s != done_d_ff;
  assign ev[IB_ALARM] = alarm_s && !alarm_d_ff;
  assign ev[IB_SEL]   = sel_s != sel_d_ff;

  // Sticky status, write one clears, set wins
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      irq_ff <= 3'h0;
    else if (wr_pend_ff && wr_addr_ff == OFS_IRQ)
      irq_ff <= (irq_ff & ~HWDATA[IRQ_W-1:0]) | ev;
    else
      irq_ff <= irq_ff | ev;
  end

  assign IRQ = |(irq_ff & mask_ff);

  // Request frozen while rigid tapping is selected
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      req_ff <= RST_RANGE;
    else if (!ctrl_ff[CB_RIGID])
      req_ff <= ctrl_ff[CB_REQ];
  end

  // Link drive: request, gears held to match request, readiness
  assign LINK.range_request         = req_ff;
  assign LINK.gear_select_1         = req_ff;
  assign LINK.gear_select_2         = req_ff;
  assign LINK.machine_ready_in      = ctrl_ff[CB_MRDY];
  assign LINK.emergency_stop_n      = !ctrl_ff[CB_ESTOP];
  assign LINK.low_contactor_status  = low_st_ff;
  assign LINK.high_contactor_status = high_st_ff;
  assign LOW_CONTACTOR              = low_ff;
  assign HIGH_CONTACTOR             = high_ff;
endmodule

/* ssr_checker.sv */
// Concurrent checks on the range switch link between the two ends.
// Assumes one clock domain; tb instantiates it beside the joined link.
`timescale 1ns/100ps
module ssr_checker
#(
  parameter int TIMEOUT_CYCLES = 40
)
(
  input wire logic CLOCK,
  input wire logic ARST_N,
  input wire logic range_request,
  input wire logic power_line_select,
  input wire logic range_switch_done,
  input wire logic low_contactor_status,
  input wire logic high_contactor_status,
  input wire logic gear_select_1,
  input wire logic gear_select_2,
  input wire logic contactor_timeout_alarm,
  input wire logic motor_power_on
);
  localparam int          DONE_MAX = TIMEOUT_CYCLES + 16;
  localparam logic [31:0] EARLY    = TIMEOUT_CYCLES - 2;
  logic [31:0]            cnt_ff;

  default clocking @(posedge CLOCK); endclocking
  default disable iff (!ARST_N);

  // Cycles since the select output last moved
  always_ff @(posedge CLOCK or negedge ARST_N)
  begin
    if (!ARST_N)
      cnt_ff <= 32'h0;
    else if ($changed(power_line_select))
      cnt_ff <= 32'h0;
    else
      cnt_ff <= cnt_ff + 32'h1;
  end

  // ----------------------------------------
  // Switch steps
  // ----------------------------------------
  sequence sel_moved_s;
    $changed(power_line_select) && (range_switch_done != power_line_select);
  endsequence
  sequence done_follows_s;
    ##[1:DONE_MAX] (range_switch_done == power_line_select || contactor_timeout_alarm);
  endsequence

  switch_ends_a: assert property (sel_moved_s |-> done_follows_s)
    else $error("completion did not follow select");
  sel_to_req_a: assert property (
    $changed(power_line_select) && !contactor_timeout_alarm |-> power_line_select == range_request)
    else $error("select moved away from request");
  done_to_sel_a: assert property (
    $changed(range_switch_done) |-> range_switch_done == power_line_select)
    else $error("completion differs from select");
  low_confirm_a: assert property (
    $rose(range_switch_done) |-> $past(low_contactor_status, 2))
    else $error("low range done without low status");
  high_confirm_a: assert property (
    $fell(range_switch_done) |-> $past(high_contactor_status, 2) && !$past(low_contactor_status, 2))
    else $error("high range done without status");
  break_make_a: assert property (!(low_contactor_status && high_contactor_status))
    else $error("both contactors closed");
  power_hold_a: assert property (
    $rose(motor_power_on) |-> range_switch_done == range_request && gear_select_1 == range_request)
    else $error("power on before switch complete");
  power_drop_a: assert property ($changed(range_request) |-> ##[1:10] !motor_power_on)
    else $error("power not dropped on request");
  gear_track_a: assert property (
    $changed(range_request) |-> ##[0:2] (gear_select_1 == range_request && gear_select_2 == range_request))
    else $error("gear selects do not follow range");
  no_early_alarm_a: assert property (cnt_ff < EARLY |-> !$rose(contactor_timeout_alarm))
    else $error("alarm raised early");
endmodule

/* ssr_tb.sv */
// Self-checking bench: both ends joined on one link, plus a second
// sequencer fed directly by the bench to model a faulty controller.
// Assumes ssr_pkg, ssr_if, the design modules and the checker are compiled first.
`timescale 1ns/100ps
module tb;
  import ssr_pkg::*;
  localparam int          TMO = 40;
  localparam int          LAG = 4;
  localparam logic [15:0] SPD [4] = '{16'h010f, 16'h0110, 16'h0100, 16'h00ff};
  localparam logic [3:0]  FLG = 4'b1001;
  logic        CLOCK = 1'b0;
  logic        ARST_N = 1'b0;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'b00;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic        hready;
  logic        irq;
  logic        hresp;
  logic        low_k;
  logic        high_k;
  logic        sw_en = 1'b1;
  logic        guard = 1'b0;
  logic [15:0] speed = 16'h0;
  logic [15:0] lvl = 16'h0100;
  logic [15:0] hys = 16'h0010;
  logic        operable;
  logic        b_req = 1'b0;
  logic        b_low = 1'b0;
  logic        b_estop_n = 1'b1;
  logic [31:0] rd;
  int          failures = 0;
  int          checks = 0;
  int          n;
  ssr_if lk ();
  ssr_if lk2 ();

  // ----------------------------------------
  // Design, checker and faulty controller
  // ----------------------------------------
  ssr_msc #(.LAG_CYCLES(LAG)) i_ssr_msc (.CLOCK(CLOCK), .ARST_N(ARST_N), .LINK(lk.msc),
    .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2),
    .HWDATA(hwdata), .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
    .IRQ(irq), .LOW_CONTACTOR(low_k), .HIGH_CONTACTOR(high_k));
  ssr_dev #(.TIMEOUT_CYCLES(TMO)) i_ssr_dev (.CLOCK(CLOCK), .ARST_N(ARST_N), .LINK(lk.dev),
    .SWITCH_ENABLE(sw_en), .DUAL_CHECK(1'b1), .SPEED_GUARD(guard), .MOTOR_SPEED(speed),
    .DETECT_LEVEL(lvl), .HYSTERESIS(hys), .OPERABLE(operable));
  ssr_dev #(.TIMEOUT_CYCLES(TMO)) i_ssr_dev_b (.CLOCK(CLOCK), .ARST_N(ARST_N),
    .LINK(lk2.dev), .SWITCH_ENABLE(sw_en), .DUAL_CHECK(1'b0), .SPEED_GUARD(guard),
    .MOTOR_SPEED(speed), .DETECT_LEVEL(lvl), .HYSTERESIS(hys), .OPERABLE());
  ssr_checker #(.TIMEOUT_CYCLES(TMO)) i_ssr_checker (.CLOCK(CLOCK), .ARST_N(ARST_N),
    .range_request(lk.range_request), .power_line_select(lk.power_line_select),
    .range_switch_done(lk.range_switch_done), .low_contactor_status(lk.low_contactor_status),
    .high_contactor_status(lk.high_contactor_status), .gear_select_1(lk.gear_select_1),
    .gear_select_2(lk.gear_select_2), .contactor_timeout_alarm(lk.contactor_timeout_alarm),
    .motor_power_on(lk.motor_power_on));
  // Bench-driven controller side of the second link
  assign lk2.range_request = b_req;
  assign lk2.gear_select_1 = b_req;
  assign lk2.gear_select_2 = b_req;
  assign lk2.low_contactor_status = b_low;
  assign lk2.high_contactor_status = 1'b1;
  assign lk2.machine_ready_in = 1'b1;
  assign lk2.emergency_stop_n = b_estop_n;

  // Clock
  always #5 CLOCK = ~CLOCK;

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One single AHB-Lite transfer; entered just after a rising edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge CLOCK); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge CLOCK); while (hready !== 1'b1);
    rd = hrdata;
  endtask

  task rdchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  task report_and_stop;
    $display("Checks %0d, failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Watchdog
  initial
  begin
    repeat (6000) @(posedge CLOCK);
    failures++;
    report_and_stop;
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial
  begin
    repeat (16) @(posedge CLOCK);
    ARST_N <= 1'b1;
    repeat (8) @(posedge CLOCK);
    rdchk(OFS_STAT, 32'h8);
    rdchk(OFS_IRQ, 32'h0);
    check({hresp, low_k, high_k}, 3'b001);
    bus(1'b1, 8'h10, 32'hf);
    rdchk(8'h10, 32'h0);
    rdchk(OFS_CTRL, 32'h0);
    check(operable, 1'b0);
    bus(1'b1, OFS_MASK, 32'h7);
    bus(1'b1, OFS_CTRL, 32'h6);
    repeat (12) @(posedge CLOCK);
    check(operable, 1'b1);
    bus(1'b1, OFS_CTRL, 32'he);
    repeat (12) @(posedge CLOCK);
    check(operable, 1'b0);
    bus(1'b1, OFS_CTRL, 32'h6);
    for (int i = 0; i < 4; i++)
    begin
      speed <= SPD[i];
      repeat (8) @(posedge CLOCK);
      check(lk.below_speed_flag, FLG[i]);
    end
    // High to low held off above speed, then released
    guard <= 1'b1;
    speed <= lvl + hys;
    repeat (8) @(posedge CLOCK);
    bus(1'b1, OFS_CTRL, 32'h7);
    repeat (30) @(posedge CLOCK);
    check(lk.power_line_select, 1'b0);
    check(operable, 1'b0);
    speed <= 16'h0;
    for (n = 0; n < 300 && lk.range_switch_done !== 1'b1; n++) @(posedge CLOCK);
    check({lk.power_line_select, lk.low_contactor_status, lk.high_contactor_status,
           lk.gear_select_1, low_k, high_k}, 6'b110110);
    repeat (12) @(posedge CLOCK);
    check(operable, 1'b1);
    rdchk(OFS_IRQ, 32'h5);
    bus(1'b1, OFS_MASK, 32'h0);
    @(posedge CLOCK);
    check(irq, 1'b0);
    bus(1'b1, OFS_MASK, 32'h7);
    @(posedge CLOCK);
    check(irq, 1'b1);
    bus(1'b1, OFS_IRQ, 32'h5);
    @(posedge CLOCK);
    check(irq, 1'b0);
    // Low to high
    bus(1'b1, OFS_CTRL, 32'h6);
    for (n = 0; n < 300 && lk.range_switch_done !== 1'b0; n++) @(posedge CLOCK);
    check({lk.power_line_select, lk.low_contactor_status, lk.high_contactor_status,
           lk.gear_select_1, low_k, high_k}, 6'b001001);
    repeat (8) @(posedge CLOCK);
    rdchk(OFS_STAT, 32'h8);
    // Rigid tapping: request bit moved but held back
    bus(1'b1, OFS_CTRL, 32'h17);
    repeat (30) @(posedge CLOCK);
    check({lk.range_request, lk.power_line_select, operable}, 3'b001);
    bus(1'b1, OFS_CTRL, 32'h6);
    // Second sequencer: disabled, single check, then late contactor
    sw_en <= 1'b0;
    b_req <= 1'b1;
    repeat (30) @(posedge CLOCK);
    check(lk2.power_line_select, 1'b0);
    b_req <= 1'b0;
    repeat (10) @(posedge CLOCK);
    sw_en <= 1'b1;
    b_req <= 1'b1;
    for (n = 0; n < 300 && lk2.power_line_select !== 1'b1; n++) @(posedge CLOCK);
    repeat (LAG) @(posedge CLOCK);
    b_low <= 1'b1;
    for (n = 0; n < 300 && lk2.range_switch_done !== 1'b1; n++) @(posedge CLOCK);
    check(lk2.range_switch_done, 1'b1);
    b_req <= 1'b0;
    for (n = 0; n < 300 && lk2.power_line_select !== 1'b0; n++) @(posedge CLOCK);
    for (n = 0; n < 300 && lk2.contactor_timeout_alarm !== 1'b1; n++) @(posedge CLOCK);
    check(n >= TMO - 4 && n <= TMO + 4, 1'b1);
    b_estop_n <= 1'b0;
    repeat (8) @(posedge CLOCK);
    check(lk2.contactor_timeout_alarm, 1'b0);
    report_and_stop;
  end
endmodule
